// ===== hdl/qbw_pkg.sv
/*
 package for the quad byte write cycle target and its host end:
 field codes, cycle positions and widths of the four-byte write cycle.
 assumes both ends share one clock and one reset.
*/
package qbw_pkg;
   localparam int          NIB_W        = 4;
   localparam int          ADDR_NIBS    = 7;
   localparam int          ADDR_W       = 28;
   localparam int          DATA_NIBS    = 8;
   localparam int          DATA_W       = 32;
   localparam logic [3:0]  START_WRITE  = 4'hE;
   localparam logic [3:0]  SIZE_QUAD    = 4'h2;
   localparam logic [3:0]  NIB_TURN     = 4'hF;
   localparam logic [3:0]  NIB_SYNC     = 4'h0;
   localparam logic [1:0]  ALIGN_MASK   = 2'h0;
   localparam logic [3:0]  ADDR_LAST    = 4'h6;
   localparam logic [3:0]  DATA_LAST    = 4'h7;
   localparam logic [3:0]  CNT_ZERO     = 4'h0;
   localparam logic [3:0]  CNT_ONE      = 4'h1;
   typedef enum logic [3:0] {
      QBW_IDLE, QBW_START, QBW_SEL, QBW_ADDR, QBW_SIZE, QBW_DATA,
      QBW_TAR_HOST, QBW_TAR_FLOAT, QBW_SYNC, QBW_TAR_DEV, QBW_RELEASE
   } qbw_state_e;
endpackage

// ===== hdl/qbw_if.sv
/*
 interface joining host and target over the nibble bus.
 resolves the shared wire itself from the enables;
 enables are active low (low means the party drives).
*/
`timescale 1ns/1ps
`default_nettype none
interface qbw_if;
   logic       frame_strobe_n;
   logic [3:0] host_nibble;
   logic       host_oe_n;
   logic [3:0] dev_nibble;
   logic       dev_oe_n;
   logic [3:0] nibble_bus_lines;
   // pulled-up shared wire: floats to all ones when nobody drives
   assign nibble_bus_lines = !host_oe_n ? host_nibble :
                             (!dev_oe_n ? dev_nibble : 4'hF);
   modport host (output frame_strobe_n, output host_nibble, output host_oe_n,
                 input nibble_bus_lines);
   modport target (input frame_strobe_n, input nibble_bus_lines,
                   output dev_nibble, output dev_oe_n);
endinterface
`default_nettype wire

// ===== hdl/qbw_target.sv
/*
 target end of the quad byte write cycle: decodes start, selection,
 address, size and data nibbles, then answers with turnaround and sync.
 assumes the host end shares this clock and reset, so the bus is sampled
 straight off the shared wire; the strap is a static level; the wire
 floats to all ones when neither end drives it.
*/
`timescale 1ns/1ps
`default_nettype none
module qbw_target
   import qbw_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   qbw_if.target                  bus,
   input  wire logic [3:0]        i_chip_select_id,
   output logic [ADDR_W-1:0]      o_addr,
   output logic [DATA_W-1:0]      o_data,
   output logic                   o_write_valid,
   output logic                   o_size_error
);
   logic [3:0]        nib;
   logic              frm_n;
   qbw_state_e        state;
   logic [3:0]        cnt;
   logic              selected;
   logic              size_ok;
   logic [ADDR_W-1:0] addr_sh;
   logic [DATA_W-1:0] data_sh;

   // the host end runs on this same clock, so the wire is sampled directly:
   // each field is taken at the rising edge that closes its own cycle, and
   // the answer lands on the cycle numbers the host counts; extra input
   // flops here would push the sync past the host's sync cycle
   assign nib   = bus.nibble_bus_lines;
   assign frm_n = bus.frame_strobe_n;

   // where the sequencer stands while the host counts each cycle:
   //   cycle 1       idle, start nibble sampled at its closing edge
   //   cycle 2       sel, selection nibble sampled
   //   cycles 3-9    addr, cnt 0 to 6
   //   cycle 10      size
   //   cycles 11-18  data, cnt 0 to 7
   //   cycle 19      tar_host, host drives all ones
   //   cycle 20      tar_float, nobody drives, pull-ups give all ones
   //   cycle 21      sync, target drives the acknowledge
   //   cycle 22      tar_dev, target drives all ones
   //   cycle 23      release, target floats, host owns the wire again
   // an unselected target walks the same sequence so that it knows when
   // the bus is free again, but it never drives and never delivers

   // cycle sequencer
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state <= QBW_IDLE;
         cnt   <= CNT_ZERO;
      end else begin
         case (state)
            QBW_IDLE: begin
               // a strobe with any other code (a read, say) is left alone
               if (!frm_n && nib == START_WRITE) begin
                  state <= QBW_SEL;
               end
            end
            QBW_SEL: begin
               // the selection field is taken by the selection process
               state <= QBW_ADDR;
               cnt   <= CNT_ZERO;
            end
            QBW_ADDR: begin
               // seven address nibbles, counted 0 to 6
               cnt <= cnt + CNT_ONE;
               if (cnt == ADDR_LAST) begin
                  state <= QBW_SIZE;
               end
            end
            QBW_SIZE: begin
               // a single size nibble, judged by the size process
               state <= QBW_DATA;
               cnt   <= CNT_ZERO;
            end
            QBW_DATA: begin
               // eight data nibbles, counted 0 to 7
               cnt <= cnt + CNT_ONE;
               if (cnt == DATA_LAST) begin
                  state <= QBW_TAR_HOST;
               end
            end
            QBW_TAR_HOST: begin
               // host still drives all ones here; nothing to sample
               state <= QBW_TAR_FLOAT;
            end
            QBW_TAR_FLOAT: begin
               // the wire floats while ownership changes hands
               state <= QBW_SYNC;
            end
            QBW_SYNC: begin
               // acknowledge on the wire for exactly this cycle
               state <= QBW_TAR_DEV;
            end
            QBW_TAR_DEV: begin
               // all ones before the drivers let go
               state <= QBW_RELEASE;
            end
            QBW_RELEASE: begin
               // drivers off; a new start may follow at once
               state <= QBW_IDLE;
            end
            default:       state <= QBW_IDLE;
         endcase
      end
   end

   // selection: latched from the selection field of every cycle, so a
   // stale match from an earlier cycle can never carry over
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         selected <= 1'b0;
      end else if (state == QBW_SEL) begin
         selected <= (nib == i_chip_select_id);
      end
   end

   // size code: only the four-byte code lets the write through
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         size_ok <= 1'b0;
      end else if (state == QBW_SIZE) begin
         size_ok <= (nib == SIZE_QUAD);
      end
   end

   // address shift register: most significant nibble enters first;
   // an unselected target leaves it untouched
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         addr_sh <= '0;
      end else if (state == QBW_ADDR && selected) begin
         addr_sh <= {addr_sh[ADDR_W-NIB_W-1:0], nib};
      end
   end

   // data shift register: low nibble first, bytes in ascending order,
   // so nibbles shift in from the top and the first ends in the bottom
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         data_sh <= '0;
      end else if (state == QBW_DATA && selected) begin
         data_sh <= {nib, data_sh[DATA_W-1:NIB_W]};
      end
   end

   // delivered address and data: captured as sync is given, held after
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_addr <= '0;
         o_data <= '0;
      end else if (state == QBW_SYNC && selected) begin
         o_addr <= {addr_sh[ADDR_W-1:2], ALIGN_MASK};
         o_data <= data_sh;
      end
   end

   // delivery pulses: one cycle each, raised by the closing edge of the
   // sync cycle, only for the selected target
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_write_valid <= 1'b0;
         o_size_error  <= 1'b0;
      end else begin
         o_write_valid <= (state == QBW_SYNC) && selected && size_ok;
         o_size_error  <= (state == QBW_SYNC) && selected && !size_ok;
      end
   end

   // nibble drivers: sync then turnaround, floated otherwise; both come
   // straight from the state so they stand for exactly their cycle, and an
   // unselected target never turns its drivers on
   always_comb begin
      bus.dev_nibble = NIB_TURN;
      bus.dev_oe_n   = 1'b1;
      if (selected && state == QBW_SYNC) begin
         bus.dev_nibble = NIB_SYNC;
         bus.dev_oe_n   = 1'b0;
      end else if (selected && state == QBW_TAR_DEV) begin
         bus.dev_nibble = NIB_TURN;
         bus.dev_oe_n   = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/qbw_host.sv
/*
 host end of the quad byte write cycle: on a request it drives start,
 selection, address, size, data and turnaround, then waits for sync.
 assumes the target replies on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module qbw_host
   import qbw_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   qbw_if.host                    bus,
   input  wire logic              i_req,
   input  wire logic [3:0]        i_sel,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_data,
   output logic                   o_busy,
   output logic                   o_done,
   output logic                   o_ack
);
   qbw_state_e        state;
   logic [3:0]        cnt;
   logic [3:0]        sel;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data;
   logic              saw_sync;

   // host sequencer: one state per field, so each field holds the wire for
   // exactly its cycle; the answer is sampled in the target's sync cycle
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state    <= QBW_IDLE;
         cnt      <= CNT_ZERO;
         sel      <= '0;
         addr     <= '0;
         data     <= '0;
         saw_sync <= 1'b0;
         o_done   <= 1'b0;
         o_ack    <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state)
            QBW_IDLE: begin
               if (i_req) begin
                  state    <= QBW_START;
                  sel      <= i_sel;
                  addr     <= i_addr;
                  data     <= i_data;
                  saw_sync <= 1'b0;
               end
            end
            QBW_START: state <= QBW_SEL;
            QBW_SEL: begin
               state <= QBW_ADDR;
               cnt   <= CNT_ZERO;
            end
            QBW_ADDR: begin
               addr <= {addr[ADDR_W-NIB_W-1:0], {NIB_W{1'b0}}};
               cnt  <= cnt + CNT_ONE;
               if (cnt == ADDR_LAST) begin
                  state <= QBW_SIZE;
               end
            end
            QBW_SIZE: begin
               state <= QBW_DATA;
               cnt   <= CNT_ZERO;
            end
            QBW_DATA: begin
               data <= {{NIB_W{1'b0}}, data[DATA_W-1:NIB_W]};
               cnt  <= cnt + CNT_ONE;
               if (cnt == DATA_LAST) begin
                  state <= QBW_TAR_HOST;
               end
            end
            QBW_TAR_HOST:  state <= QBW_TAR_FLOAT;
            QBW_TAR_FLOAT: state <= QBW_SYNC;
            QBW_SYNC: begin
               state    <= QBW_TAR_DEV;
               saw_sync <= (bus.nibble_bus_lines == NIB_SYNC);
            end
            QBW_TAR_DEV:   state <= QBW_RELEASE;
            QBW_RELEASE: begin
               state  <= QBW_IDLE;
               o_done <= 1'b1;
               o_ack  <= saw_sync;
            end
            default: state <= QBW_IDLE;
         endcase
      end
   end

   assign o_busy = (state != QBW_IDLE);

   // pin drive: host owns the bus from start through its turnaround
   always_comb begin
      bus.frame_strobe_n = 1'b1;
      bus.host_nibble    = NIB_TURN;
      bus.host_oe_n      = 1'b1;
      case (state)
         QBW_START: begin
            bus.frame_strobe_n = 1'b0;
            bus.host_nibble    = START_WRITE;
            bus.host_oe_n      = 1'b0;
         end
         QBW_SEL: begin
            bus.host_nibble = sel;
            bus.host_oe_n   = 1'b0;
         end
         QBW_ADDR: begin
            bus.host_nibble = addr[ADDR_W-1:ADDR_W-NIB_W];
            bus.host_oe_n   = 1'b0;
         end
         QBW_SIZE: begin
            bus.host_nibble = SIZE_QUAD;
            bus.host_oe_n   = 1'b0;
         end
         QBW_DATA: begin
            bus.host_nibble = data[NIB_W-1:0];
            bus.host_oe_n   = 1'b0;
         end
         QBW_TAR_HOST: begin
            bus.host_nibble = NIB_TURN;
            bus.host_oe_n   = 1'b0;
         end
         default: begin
            bus.host_nibble = NIB_TURN;
         end
      endcase
   end
endmodule
`default_nettype wire

// ===== verif/qbw_bus_sva.sv
/*
 checker for the nibble bus between host and target: framing, turnaround,
 sync answer and silence when unselected.
 assumes instantiation beside the interface, with the target's strap.
*/
`timescale 1ns/1ps
`default_nettype none
module qbw_bus_sva
   import qbw_pkg::*;
(
   input wire logic       i_clock,
   input wire logic       i_rst,
   input wire logic       frame_strobe_n,
   input wire logic [3:0] host_nibble,
   input wire logic       host_oe_n,
   input wire logic [3:0] dev_nibble,
   input wire logic       dev_oe_n,
   input wire logic [3:0] nibble_bus_lines,
   input wire logic [3:0] i_chip_select_id
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // start field seen on the wire with the strobe low
   sequence start_s;
      !frame_strobe_n && nibble_bus_lines == START_WRITE;
   endsequence
   a_size_field: assert property (start_s |-> ##9 nibble_bus_lines == SIZE_QUAD)
      else $error("size field not quad");
   a_host_turn: assert property (start_s |-> ##18 (!host_oe_n && host_nibble == NIB_TURN)
      ##1 host_oe_n)
      else $error("host turnaround wrong");
   a_float_gap: assert property ($rose(host_oe_n) |-> dev_oe_n && nibble_bus_lines == NIB_TURN)
      else $error("bus not floating after host release");
   a_no_clash: assert property (host_oe_n || dev_oe_n)
      else $error("both ends drive the bus");
   a_sync_first: assert property ($fell(dev_oe_n) |-> dev_nibble == NIB_SYNC
      ##1 (!dev_oe_n && dev_nibble == NIB_TURN) ##1 dev_oe_n)
      else $error("target answer sequence wrong");
   a_sync_timing: assert property ((start_s ##1 nibble_bus_lines == i_chip_select_id)
      |-> ##19 (!dev_oe_n && dev_nibble == NIB_SYNC))
      else $error("sync missing after selected write");
   a_unsel_quiet: assert property ((start_s ##1 nibble_bus_lines != i_chip_select_id)
      |=> dev_oe_n [*8] ##1 dev_oe_n [*8] ##1 dev_oe_n [*8])
      else $error("unselected target drove the bus");
   a_release_high: assert property ($rose(dev_oe_n) |-> nibble_bus_lines == NIB_TURN)
      else $error("bus not released after answer");
   a_turn_release: assert property ($fell(dev_oe_n) |=> ##1 $rose(dev_oe_n))
      else $error("target drove other than two cycles");
endmodule
`default_nettype wire

// ===== verif/testbench.sv
/*
 self-checking bench: host and target joined on one bus, a second target
 fed by a scripted driver for faults.
 assumes one 50 MHz clock shared by both ends, so the sync is on time.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import qbw_pkg::*;
   logic              i_clock, i_rst, req, done, ack, a_valid, a_err, b_valid, b_err, busy;
   logic [3:0]        sel;
   logic [ADDR_W-1:0] addr, a_addr, b_addr, got_addr;
   logic [DATA_W-1:0] data, a_data, b_data, got_data;
   logic              got_ack;
   logic [3:0]        seq [1:25];
   int                err_count, check_count, n_valid, n_err, n_done;
   qbw_if bus_a();
   qbw_if bus_b();
   qbw_host qbw_host_i (.i_clock(i_clock), .i_rst(i_rst), .bus(bus_a), .i_req(req),
      .i_sel(sel), .i_addr(addr), .i_data(data), .o_busy(busy), .o_done(done), .o_ack(ack));
   qbw_target qbw_target_i (.i_clock(i_clock), .i_rst(i_rst), .bus(bus_a),
      .i_chip_select_id(4'h5), .o_addr(a_addr), .o_data(a_data),
      .o_write_valid(a_valid), .o_size_error(a_err));
   qbw_target qbw_target_b_i (.i_clock(i_clock), .i_rst(i_rst), .bus(bus_b),
      .i_chip_select_id(4'h3), .o_addr(b_addr), .o_data(b_data),
      .o_write_valid(b_valid), .o_size_error(b_err));
   qbw_bus_sva qbw_bus_sva_i (.i_clock(i_clock), .i_rst(i_rst),
      .frame_strobe_n(bus_a.frame_strobe_n), .host_nibble(bus_a.host_nibble),
      .host_oe_n(bus_a.host_oe_n), .dev_nibble(bus_a.dev_nibble),
      .dev_oe_n(bus_a.dev_oe_n), .nibble_bus_lines(bus_a.nibble_bus_lines),
      .i_chip_select_id(4'h5));
   // free-running clock
   always #10 i_clock = ~i_clock;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // expected wire contents of one write cycle, cycle numbers as index
   task automatic build(input logic [3:0] s, input logic [3:0] sz, input bit hit);
      for (int i = 1; i < 26; i++) seq[i] = NIB_TURN;
      seq[1] = START_WRITE;
      seq[2] = s;
      for (int i = 0; i < 7; i++) seq[3+i] = addr[27-4*i -: 4];
      seq[10] = sz;
      for (int i = 0; i < 8; i++) seq[11+i] = data[4*i +: 4];
      if (hit) seq[21] = NIB_SYNC;
      sel = s;
      n_valid = 0;
      n_err = 0;
      n_done = 0;
   endtask
   // one cycle on, collecting pulses of both targets and the host
   task automatic tick();
      @(negedge i_clock);
      if (a_valid === 1'b1 || b_valid === 1'b1) begin
         n_valid++;
         got_addr = (a_valid === 1'b1) ? a_addr : b_addr;
         got_data = (a_valid === 1'b1) ? a_data : b_data;
      end
      if (a_err === 1'b1 || b_err === 1'b1) n_err++;
      if (done === 1'b1) begin
         n_done++;
         got_ack = ack;
      end
   endtask
   task automatic judge(input bit hit, input bit bad);
      check(n_valid, hit);
      check(n_err, bad);
      if (hit) check(got_addr, {addr[27:2], 2'b00});
      if (hit) check(got_data, data);
   endtask
   // write through the host pair, wire watched cycle by cycle
   task automatic t_pair(input logic [3:0] s, input bit hit);
      int k;
      build(s, SIZE_QUAD, hit);
      req = 1'b1;
      k = 0;
      while (!(bus_a.frame_strobe_n === 1'b0 && bus_a.nibble_bus_lines === START_WRITE)) begin
         tick();
         req = 1'b0;
         k++;
         if (k > 10) begin
            err_count++;
            tally_and_finish();
         end
      end
      check(busy, 1'b1);
      for (int c = 2; c < 26; c++) begin
         tick();
         check(bus_a.nibble_bus_lines, seq[c]);
      end
      repeat (10) tick();
      judge(hit, 0);
      check(n_done, 1);
      check(got_ack, hit);
      check(busy, 1'b0);
      $display("pair write done");
   endtask
   // scripted host on the second bus, may break the size rule
   task automatic t_drv(input logic [3:0] s, input logic [3:0] sz);
      build(s, sz, s == 4'h3);
      for (int c = 1; c < 20; c++) begin
         bus_b.frame_strobe_n = (c != 1);
         bus_b.host_oe_n = 1'b0;
         bus_b.host_nibble = seq[c];
         tick();
      end
      bus_b.frame_strobe_n = 1'b1;
      bus_b.host_oe_n = 1'b1;
      bus_b.host_nibble = 4'h0;
      for (int c = 21; c < 26; c++) begin
         tick();
         check(bus_b.nibble_bus_lines, seq[c]);
      end
      repeat (4) tick();
      judge(s == 4'h3 && sz == SIZE_QUAD, s == 4'h3 && sz != SIZE_QUAD);
      $display("driver write done");
   endtask
   initial begin
      i_clock = 1'b0;
      i_rst = 1'b1;
      req = 1'b0;
      sel = 4'h0;
      addr = 28'h9ABCDE7;
      data = 32'h8A6B5C4D;
      err_count = 0;
      check_count = 0;
      bus_b.frame_strobe_n = 1'b1;
      bus_b.host_oe_n = 1'b1;
      bus_b.host_nibble = 4'hF;
      repeat (12) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      t_pair(4'h5, 1);
      t_pair(4'h6, 0);
      addr = 28'h1234563;
      data = 32'hF00DBEEF;
      t_drv(4'h3, SIZE_QUAD);
      t_drv(4'h3, 4'h0);
      t_drv(4'h9, SIZE_QUAD);
      tally_and_finish();
   end
endmodule
`default_nettype wire
